// File: core/dcmp_pkg.sv
// Operation
// - Two independent 36-bit mail registers exist, one carrying words from port A to port B and one from port B to port A, apart from the FIFO.
// - A high mail select on a port steers that port's transfer to its mail register, a low one steers a port A write or a port B read to the FIFO.
// - A port A clock rise with a selected write and high mail select captures the port A data bus into the A-to-B mail register.
// - A port B clock rise with a selected write and high mail select captures the port B data bus into the B-to-A mail register.
// - An accepted write drives that register's mail flag low to show new mail for the opposite port.
// - While a mail flag is low, further writes to that register are ignored and the stored word is kept.
// - Enabled port B outputs show the FIFO output word when port B mail select is low and the A-to-B mail register when high.
// - Enabled port A outputs always show the B-to-A mail register, whatever the mail select.
// - A port B clock rise with a selected read and high mail select sets the A-to-B mail flag high.
// - A port A clock rise with a selected read and high mail select sets the B-to-A mail flag high.
// - Reading a mail register never changes it; only an accepted write does.
package dcmp_pkg;
   localparam int          DATA_WIDTH    = 36;
   localparam int          SYNC_STAGES   = 3;
   localparam logic [35:0] MAIL_RESET    = 36'h0_0000_0000;
   localparam logic        FLAG_N_RESET  = 1'b1;   // no mail waiting
   // level of the direction pin that selects a write on each port
   localparam logic        A_WRITE_LEVEL = 1'b1;
   localparam logic        B_WRITE_LEVEL = 1'b0;
endpackage : dcmp_pkg

// File: core/dcmp_port_if.sv
`timescale 1ns/1ps
interface dcmp_port_if;
   logic        mailWrite;   // one-cycle pulse
   logic        mailRead;    // one-cycle pulse
   logic        fifoWrite;   // one-cycle pulse
   logic        fifoRead;    // one-cycle pulse
   logic        mailSelect;  // level, synchronised
   logic        outActive;   // level, synchronised
   logic [35:0] dataWord;    // synchronised data bus

   modport sync (output mailWrite, mailRead, fifoWrite, fifoRead, mailSelect, outActive,
                 dataWord);
   modport core (input mailWrite, mailRead, fifoWrite, fifoRead, mailSelect, outActive,
                 dataWord);
endinterface : dcmp_port_if

// File: core/dcmp_port_sync.sv
`timescale 1ns/1ps
module dcmp_port_sync #(
   parameter logic WRITE_LEVEL = 1'b1
) (
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic        portClock,
   input  wire logic        chipSelectN,
   input  wire logic        writeNotRead,
   input  wire logic        transferEnable,
   input  wire logic        mailSelect,
   input  wire logic [35:0] dataIn,
   dcmp_port_if.sync        port
);
   localparam int W = 4 + dcmp_pkg::DATA_WIDTH;
   // chains wake up showing an idle port (clock low, chip select off), so the
   // output enable cannot flicker high in the first cycles after reset
   localparam logic [W:0] CHAIN_IDLE = {2'b01, {(W-1){1'b0}}};

   logic         clkState;

   // three-stage chain; stage 0 feeds only stage 1
   logic [W:0] chain0;
   logic [W:0] chain1;
   logic [W:0] chain2;
   wire  [W:0] pinBundle = {portClock, chipSelectN, writeNotRead, transferEnable, mailSelect,
                            dataIn};

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         chain0 <= CHAIN_IDLE;
         chain1 <= CHAIN_IDLE;
         chain2 <= CHAIN_IDLE;
      end else begin
         chain0 <= pinBundle;
         chain1 <= chain0;
         chain2 <= chain1;
      end
   end

   // a clock change counts once stages one and two agree
   wire clkAgree = (chain1[W] == chain2[W]);
   wire clkRise  = clkAgree & chain2[W] & ~clkState;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) clkState <= 1'b0;
      else if (clkAgree) clkState <= chain2[W];
   end

   // controls sampled alongside the clock, so setup at the pin carries over
   wire csN   = chain2[W-1];
   wire dir   = chain2[W-2];
   wire en    = chain2[W-3];
   wire mbSel = chain2[W-4];
   wire isWr  = ~csN & en & (dir == WRITE_LEVEL);
   wire isRd  = ~csN & en & (dir != WRITE_LEVEL);

   // mail select steers each transfer to mailbox or FIFO
   assign port.mailWrite  = clkRise & isWr & mbSel;
   assign port.mailRead   = clkRise & isRd & mbSel;
   assign port.fifoWrite  = clkRise & isWr & ~mbSel;
   assign port.fifoRead   = clkRise & isRd & ~mbSel;
   assign port.mailSelect = mbSel;
   assign port.outActive  = ~csN & (dir != WRITE_LEVEL);
   assign port.dataWord   = chain2[dcmp_pkg::DATA_WIDTH-1:0];
endmodule : dcmp_port_sync

// File: core/dcmp_mailbox.sv
`timescale 1ns/1ps
module dcmp_mailbox (
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic        portAClock,
   input  wire logic        portAChipSelectN,
   input  wire logic        portAWriteNotRead,
   input  wire logic        portATransferEnable,
   input  wire logic        portAMailSelect,
   input  wire logic [35:0] portADataIn,
   output logic      [35:0] portADataOut,
   output logic             portADataOe,
   input  wire logic        portBClock,
   input  wire logic        portBChipSelectN,
   input  wire logic        portBWriteNotRead,
   input  wire logic        portBTransferEnable,
   input  wire logic        portBMailSelect,
   input  wire logic [35:0] portBDataIn,
   output logic      [35:0] portBDataOut,
   output logic             portBDataOe,
   input  wire logic [35:0] fifoOutputWord,
   output logic             fifoWriteStrobe,
   output logic      [35:0] fifoWriteWord,
   output logic             fifoReadStrobe,
   output logic             aToBMailFlagN,
   output logic             bToAMailFlagN
);
   dcmp_port_if portA ();
   dcmp_port_if portB ();

   logic [35:0] aToBMailReg;
   logic [35:0] bToAMailReg;

   dcmp_port_sync #(.WRITE_LEVEL(dcmp_pkg::A_WRITE_LEVEL)) syncA (
      .sys_clk        (sys_clk),
      .rst_n          (rst_n),
      .portClock      (portAClock),
      .chipSelectN    (portAChipSelectN),
      .writeNotRead   (portAWriteNotRead),
      .transferEnable (portATransferEnable),
      .mailSelect     (portAMailSelect),
      .dataIn         (portADataIn),
      .port           (portA)
   );

   dcmp_port_sync #(.WRITE_LEVEL(dcmp_pkg::B_WRITE_LEVEL)) syncB (
      .sys_clk        (sys_clk),
      .rst_n          (rst_n),
      .portClock      (portBClock),
      .chipSelectN    (portBChipSelectN),
      .writeNotRead   (portBWriteNotRead),
      .transferEnable (portBTransferEnable),
      .mailSelect     (portBMailSelect),
      .dataIn         (portBDataIn),
      .port           (portB)
   );

   // a write is taken only while the flag shows the box empty
   wire acceptAWrite = portA.mailWrite & aToBMailFlagN;
   wire acceptBWrite = portB.mailWrite & bToAMailFlagN;

   // an accepted write beats a same-cycle read, so new mail is never lost
   wire next_aToBFlagN = acceptAWrite ? 1'b0 : (portB.mailRead ? 1'b1 : aToBMailFlagN);
   wire next_bToAFlagN = acceptBWrite ? 1'b0 : (portA.mailRead ? 1'b1 : bToAMailFlagN);

   // mail registers change only on accepted writes, never on reads
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         aToBMailReg <= dcmp_pkg::MAIL_RESET;
         bToAMailReg <= dcmp_pkg::MAIL_RESET;
      end else begin
         if (acceptAWrite) aToBMailReg <= portA.dataWord;
         if (acceptBWrite) bToAMailReg <= portB.dataWord;
      end
   end

   // write drives flag low, opposite read sets it high
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         aToBMailFlagN <= dcmp_pkg::FLAG_N_RESET;
         bToAMailFlagN <= dcmp_pkg::FLAG_N_RESET;
      end else begin
         aToBMailFlagN <= next_aToBFlagN;
         bToAMailFlagN <= next_bToAFlagN;
      end
   end

   // port B shows FIFO or mail by select; port A always mail
   wire [35:0] next_portBData = portB.mailSelect ? aToBMailReg : fifoOutputWord;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         portADataOut <= dcmp_pkg::MAIL_RESET;
         portADataOe  <= 1'b0;
         portBDataOut <= dcmp_pkg::MAIL_RESET;
         portBDataOe  <= 1'b0;
      end else begin
         portADataOut <= bToAMailReg;
         portADataOe  <= portA.outActive;
         portBDataOut <= next_portBData;
         portBDataOe  <= portB.outActive;
      end
   end

   // port A FIFO writes and port B FIFO reads pass on as strobes for the array logic
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         fifoWriteStrobe <= 1'b0;
         fifoWriteWord   <= dcmp_pkg::MAIL_RESET;
         fifoReadStrobe  <= 1'b0;
      end else begin
         fifoWriteStrobe <= portA.fifoWrite;
         fifoWriteWord   <= portA.dataWord;
         fifoReadStrobe  <= portB.fifoRead;
      end
   end
endmodule : dcmp_mailbox

// File: test/dcmp_fifo_model.sv
`timescale 1ns/1ps
module dcmp_fifo_model (
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic        fifoReadStrobe,
   output logic      [35:0] fifoOutputWord
);
   // fifo output register stand-in: every read moves on to the next word
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) fifoOutputWord <= 36'h0_0000_0100;
      else if (fifoReadStrobe) fifoOutputWord <= fifoOutputWord + 36'h0_0000_0001;
   end
endmodule : dcmp_fifo_model

// File: test/dcmp_mailbox_asserts.sv
`timescale 1ns/1ps
module dcmp_mailbox_asserts (
   input wire logic        sys_clk,
   input wire logic        rst_n,
   input wire logic        portAClock,
   input wire logic        portAChipSelectN,
   input wire logic        portAWriteNotRead,
   input wire logic        portATransferEnable,
   input wire logic        portAMailSelect,
   input wire logic [35:0] portADataOut,
   input wire logic        portADataOe,
   input wire logic        portBClock,
   input wire logic        portBChipSelectN,
   input wire logic        portBWriteNotRead,
   input wire logic        portBTransferEnable,
   input wire logic        portBMailSelect,
   input wire logic [35:0] portBDataIn,
   input wire logic        portBDataOe,
   input wire logic        aToBMailFlagN,
   input wire logic        bToAMailFlagN
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // decoded mailbox transfers; the bench holds pins steady around each port clock rise
   wire aCmd   = !portAChipSelectN && portATransferEnable && portAMailSelect;
   wire bCmd   = !portBChipSelectN && portBTransferEnable && portBMailSelect;
   wire aWrite = portAWriteNotRead == dcmp_pkg::A_WRITE_LEVEL;
   wire bWrite = portBWriteNotRead == dcmp_pkg::B_WRITE_LEVEL;
   a_a_write_flag: assert property ($rose(portAClock) && aCmd && aWrite && aToBMailFlagN
      |-> ##[2:6] !aToBMailFlagN) else $error("port a mail write not flagged");
   a_b_write_flag: assert property ($rose(portBClock) && bCmd && bWrite && bToAMailFlagN
      |-> ##[2:6] !bToAMailFlagN) else $error("port b mail write not flagged");
   a_b_read_clear: assert property ($rose(portBClock) && bCmd && !bWrite
      |-> ##[2:6] aToBMailFlagN) else $error("port b mail read left flag low");
   a_a_read_clear: assert property ($rose(portAClock) && aCmd && !aWrite
      |-> ##[2:6] bToAMailFlagN) else $error("port a mail read left flag low");
   a_a_data_path: assert property ($rose(portBClock) && bCmd && bWrite && bToAMailFlagN
      |-> ##[3:8] portADataOut == portBDataIn) else $error("port b mail word not on port a");
   a_a_out_guard: assert property ($changed(portADataOut) |-> !bToAMailFlagN)
      else $error("port a word changed without accepted write");
   a_a_oe_level: assert property ((!portAChipSelectN && !aWrite)[*6] |-> portADataOe)
      else $error("port a outputs not enabled for read");
   a_b_oe_level: assert property ((!portBChipSelectN && !bWrite)[*6] |-> portBDataOe)
      else $error("port b outputs not enabled for read");
endmodule : dcmp_mailbox_asserts
bind dcmp_mailbox dcmp_mailbox_asserts i_dcmp_mailbox_asserts (.*);

// File: test/dcmp_mailbox_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin miscompares++; \
   $display("BAD %s exp %h got %h", n, e, s); end end
module dcmp_mailbox_tb;
   logic        sys_clk = 1'b0, rst_n = 1'b0, portAClock = 1'b0, portBClock = 1'b0;
   logic        portAChipSelectN = 1'b1, portAWriteNotRead = 1'b0, portATransferEnable = 1'b0;
   logic        portBChipSelectN = 1'b1, portBWriteNotRead = 1'b0, portBTransferEnable = 1'b0;
   logic        portAMailSelect = 1'b0, portBMailSelect = 1'b0;
   logic [35:0] portADataIn = 36'h0_0000_0000, portBDataIn = 36'h0_0000_0000;
   logic [35:0] portADataOut, portBDataOut, fifoOutputWord, fifoWriteWord;
   logic        portADataOe, portBDataOe, fifoWriteStrobe, fifoReadStrobe;
   logic        aToBMailFlagN, bToAMailFlagN;
   int          miscompares = 0, tests_run = 0;
   int          fifoWrites = 0;
   logic [35:0] fifoWordSeen = 36'h0_0000_0000;
   always #12.5 sys_clk = ~sys_clk;
   dcmp_mailbox i_dcmp_mailbox (.*);
   dcmp_fifo_model i_dcmp_fifo_model (.*);
   // the write strobe stands one cycle: count it and keep the word that came with it
   always @(negedge sys_clk) begin
      if (fifoWriteStrobe === 1'b1) begin
         fifoWrites++;
         fifoWordSeen = fifoWriteWord;
      end
   end
   // one port transfer; setup and high phases of 6 cycles and a low phase of 8 keep the sampled port clock well above 3
   task xfer(input bit b, input logic wr, input logic sel, input logic [35:0] d);
      @(negedge sys_clk);
      if (b) {portBChipSelectN, portBTransferEnable, portBMailSelect, portBDataIn} = {2'b01, sel, d};
      else {portAChipSelectN, portATransferEnable, portAMailSelect, portADataIn} = {2'b01, sel, d};
      portAWriteNotRead = b ? portAWriteNotRead : wr ~^ dcmp_pkg::A_WRITE_LEVEL;
      portBWriteNotRead = b ? wr ~^ dcmp_pkg::B_WRITE_LEVEL : portBWriteNotRead;
      repeat (6) @(negedge sys_clk);
      {portBClock, portAClock} = b ? 2'b10 : 2'b01;
      repeat (6) @(negedge sys_clk);
      {portBClock, portAClock} = 2'b00;
      repeat (8) @(negedge sys_clk);
   endtask : xfer
   task write_word(input bit b, input logic sel, input logic [35:0] d);
      xfer(b, 1'b1, sel, d);
   endtask : write_word
   task read_word(input bit b, input logic sel);
      xfer(b, 1'b0, sel, 36'h0_0000_0000);
   endtask : read_word
   task close_out;
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : close_out
   // watchdog: the whole sequence needs well under 400 cycles
   initial begin
      repeat (3000) @(posedge sys_clk);
      miscompares++;
      close_out();
   end
   initial begin
      repeat (16) @(negedge sys_clk);
      rst_n = 1'b1;
      @(negedge sys_clk);
      `CHK("oeIdle", 2'b00, {portADataOe, portBDataOe})
      repeat (3) @(negedge sys_clk);
      `CHK("flags", 2'b11, {aToBMailFlagN, bToAMailFlagN})
      write_word(0, 1, 36'h1_2345_6789);
      `CHK("aOe", 1'b0, portADataOe)
      write_word(0, 1, 36'hF_EDCB_A987); // second write meets a low flag
      `CHK("abFlag", 1'b0, aToBMailFlagN)
      read_word(1, 1);
      `CHK("bOut", 36'h1_2345_6789, portBDataOut)
      `CHK("abFlag", 1'b1, aToBMailFlagN)
      read_word(1, 1);
      `CHK("bOut", 36'h1_2345_6789, portBDataOut)
      $display("test a_to_b done");
      write_word(1, 1, 36'hA_BCDE_F012);
      `CHK("bOe", 1'b0, portBDataOe)
      read_word(0, 0); // read with fifo select leaves mail alone
      `CHK("baFlag", 1'b0, bToAMailFlagN)
      `CHK("aOut", 36'hA_BCDE_F012, portADataOut)
      `CHK("aOe", 1'b1, portADataOe)
      read_word(0, 1);
      `CHK("baFlag", 1'b1, bToAMailFlagN)
      `CHK("aOut", 36'hA_BCDE_F012, portADataOut)
      $display("test b_to_a done");
      `CHK("fifoWrites", 0, fifoWrites)
      write_word(0, 0, 36'h5_5555_AAAA); // selects low as in depth expansion
      `CHK("fifoWrites", 1, fifoWrites)
      `CHK("fifoSeen", 36'h5_5555_AAAA, fifoWordSeen)
      `CHK("fifoWord", 36'h5_5555_AAAA, fifoWriteWord)
      `CHK("abFlag", 1'b1, aToBMailFlagN)
      read_word(1, 0);
      `CHK("bOut", 36'h0_0000_0101, portBDataOut)
      `CHK("bOe", 1'b1, portBDataOe)
      $display("test fifo_path done");
      close_out();
   end
endmodule : dcmp_mailbox_tb
